/* File: verilog/rtt_pkg.sv */
// shared constants and types for the relay timeout timer
package rtt_pkg;

    // timebase periods for debounce and on-time
    localparam int RTT_DEBOUNCE_PERIODS = 6;
    localparam int RTT_DELAY_PERIODS = 73728;

    // reset values of the held state
    localparam logic RTT_RELAY_RST = 1'h0;
    localparam logic RTT_LVL_RST = 1'h0;

    // the three push-button inputs, active high
    typedef struct packed {
        logic toggle;
        logic sw_on;
        logic sw_off;
    } rtt_keys_t;

    localparam rtt_keys_t RTT_KEYS_RST = 3'h0;

    // relay output state
    typedef enum logic {
        RTT_RELAY_IDLE,
        RTT_RELAY_ACTIVE
    } rtt_relay_t;

endpackage

/* File: verilog/rtt_relay_timer.sv */
// relay timeout timer: input sync, shared debounce, delay count, relay drive
//
// What this block does
// - debounce lasts six timebase periods
// - on-time is 73728 timebase periods from activation
// - reset puts all state in defined values
// - relay stays off after reset until trigger
// - first toggle press switches relay on
// - toggle press while on switches relay off
// - each accepted toggle press inverts exactly once
// - without second press, relay ends at expiry
// - switch-on press activates relay, starts delay
// - switch-off press deactivates relay, ends delay
// - switch-on activation ends automatically at expiry
// - held switch-on still lets delay expire
// - no retrigger; activity never extends delay
// - debounce acts on press and release
// - all three key inputs share one debounce stage
`timescale 1ns/1ps

module rtt_relay_timer
    import rtt_pkg::*;
#(
    parameter int DEBOUNCE_TICKS = RTT_DEBOUNCE_PERIODS,
    parameter int DELAY_TICKS = RTT_DELAY_PERIODS
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic rc_timebase_input_i,
    input wire logic toggle_i,
    input wire logic sw_on_i,
    input wire logic sw_off_i,
    output logic relay_drive_o,
    output logic [2:0] keys_debounced_o
);

    localparam int DBW = (DEBOUNCE_TICKS > 1) ? $clog2(DEBOUNCE_TICKS) : 1;
    localparam int DLW = (DELAY_TICKS > 1) ? $clog2(DELAY_TICKS) : 1;
    localparam logic [DBW-1:0] DEB_LAST = DBW'(DEBOUNCE_TICKS - 1);
    localparam logic [DLW-1:0] DLY_LAST = DLW'(DELAY_TICKS - 1);
    localparam logic [DBW-1:0] DEB_ZERO = '0;
    localparam logic [DLW-1:0] DLY_ZERO = '0;
    localparam logic [DBW-1:0] DEB_ONE = DBW'(1);
    localparam logic [DLW-1:0] DLY_ONE = DLW'(1);

    // rising edge of a held level against its new value
    function automatic logic rise(input logic old_v, input logic new_v);
        rise = ~old_v & new_v;
    endfunction

    // three-stage synchronisers; stage one feeds stage two only
    logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
    rtt_keys_t keys_s1_ff, keys_s2_ff, keys_s3_ff;
    logic osc_lvl_ff;
    rtt_keys_t keys_lvl_ff;
    logic nxt_osc_lvl;
    rtt_keys_t nxt_keys_lvl;

    // debounce state, one stage for all keys
    rtt_keys_t keys_prev_ff;
    rtt_keys_t keys_deb_ff;
    rtt_keys_t nxt_keys_deb;
    logic [DBW-1:0] deb_cnt_ff;
    logic [DBW-1:0] nxt_deb_cnt;

    // relay state and delay count
    rtt_relay_t relay_ff;
    rtt_relay_t nxt_relay;
    logic [DLW-1:0] dly_cnt_ff;
    logic [DLW-1:0] nxt_dly_cnt;

    wire logic osc_tick;
    wire logic lvl_moved;
    wire logic deb_accept;
    wire logic tog_rise;
    wire logic on_rise;
    wire logic off_rise;
    wire logic relay_on;
    wire logic expire;

    // pin sampling chain
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_s1_ff <= RTT_LVL_RST;
            osc_s2_ff <= RTT_LVL_RST;
            osc_s3_ff <= RTT_LVL_RST;
            keys_s1_ff <= RTT_KEYS_RST;
            keys_s2_ff <= RTT_KEYS_RST;
            keys_s3_ff <= RTT_KEYS_RST;
        end
        else
        begin
            osc_s1_ff <= rc_timebase_input_i;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
            keys_s1_ff <= {toggle_i, sw_on_i, sw_off_i};
            keys_s2_ff <= keys_s1_ff;
            keys_s3_ff <= keys_s2_ff;
        end
    end

    // a level counts only once stages two and three agree
    assign nxt_osc_lvl = (osc_s2_ff == osc_s3_ff) ? osc_s3_ff : osc_lvl_ff;
    assign nxt_keys_lvl = (keys_s2_ff == keys_s3_ff) ? keys_s3_ff
                                                     : keys_lvl_ff;
    assign osc_tick = rise(osc_lvl_ff, nxt_osc_lvl);

    // shared debounce: any key change restarts the count
    assign lvl_moved = (keys_lvl_ff != keys_prev_ff);
    assign deb_accept = !lvl_moved && (keys_lvl_ff != keys_deb_ff)
                        && osc_tick && (deb_cnt_ff == DEB_LAST);
    // press and release both wait the full interval
    assign nxt_keys_deb = deb_accept ? keys_lvl_ff : keys_deb_ff;
    assign nxt_deb_cnt = (lvl_moved || keys_lvl_ff == keys_deb_ff
                          || deb_accept) ? DEB_ZERO
                       : osc_tick ? deb_cnt_ff + DEB_ONE : deb_cnt_ff;

    // accepted press edges, active high inputs
    assign tog_rise = rise(keys_deb_ff.toggle, nxt_keys_deb.toggle);
    assign on_rise = rise(keys_deb_ff.sw_on, nxt_keys_deb.sw_on);
    assign off_rise = rise(keys_deb_ff.sw_off, nxt_keys_deb.sw_off);

    assign relay_on = (relay_ff == RTT_RELAY_ACTIVE);
    assign expire = relay_on && osc_tick
                    && (dly_cnt_ff == DLY_LAST);

    // relay decision; off wins over every other request
    always_comb
    begin
        nxt_relay = relay_ff;
        unique case (relay_ff)
            RTT_RELAY_IDLE:
            begin
                if (!off_rise && (on_rise || tog_rise))
                    nxt_relay = RTT_RELAY_ACTIVE;
            end
            RTT_RELAY_ACTIVE:
            begin
                // held switch-on is no level hold, only edges act
                if (off_rise || tog_rise || expire)
                    nxt_relay = RTT_RELAY_IDLE;
            end
        endcase
    end

    // delay count runs only while active; never reloaded when on
    assign nxt_dly_cnt = (nxt_relay != RTT_RELAY_ACTIVE) ? DLY_ZERO
                       : (relay_on && osc_tick) ? dly_cnt_ff + DLY_ONE
                       : dly_cnt_ff;

    // held state; reset clears everything and drops the relay
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_lvl_ff <= RTT_LVL_RST;
            keys_lvl_ff <= RTT_KEYS_RST;
            keys_prev_ff <= RTT_KEYS_RST;
            keys_deb_ff <= RTT_KEYS_RST;
            deb_cnt_ff <= DEB_ZERO;
            dly_cnt_ff <= DLY_ZERO;
            relay_ff <= RTT_RELAY_IDLE;
        end
        else
        begin
            osc_lvl_ff <= nxt_osc_lvl;
            keys_lvl_ff <= nxt_keys_lvl;
            keys_prev_ff <= keys_lvl_ff;
            keys_deb_ff <= nxt_keys_deb;
            deb_cnt_ff <= nxt_deb_cnt;
            dly_cnt_ff <= nxt_dly_cnt;
            relay_ff <= nxt_relay;
        end
    end

    assign relay_drive_o = relay_on;
    assign keys_debounced_o = keys_deb_ff;

    // checks on the debounce and relay behaviour
    sequence s_idle_press;
        !relay_on && tog_rise && !off_rise;
    endsequence

    sequence s_active_press;
        relay_on && tog_rise;
    endsequence

    AST_FIRST_ON: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_idle_press |=> relay_on)
        else $error("idle toggle press did not turn relay on");

    AST_TOGGLE_OFF: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_active_press |=> !relay_on && dly_cnt_ff == DLY_ZERO)
        else $error("active toggle press did not turn relay off");

    AST_OFF_WINS: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        off_rise |=> !relay_on)
        else $error("switch-off press left relay on");

    AST_ON_CAUSE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(relay_on) |-> $past(on_rise || tog_rise)
                            && dly_cnt_ff == DLY_ZERO)
        else $error("relay rose without an accepted press");

    AST_EXPIRY: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        relay_on && osc_tick && dly_cnt_ff == DLY_LAST |=> !relay_on)
        else $error("relay stayed on past the delay");

    AST_NO_RETRIG: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        relay_on && $past(relay_on) |->
            dly_cnt_ff == $past(dly_cnt_ff) + DLW'($past(osc_tick)))
        else $error("delay count restarted or skipped while on");

    AST_DEB_STABLE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        keys_deb_ff != $past(keys_deb_ff) |->
            $past(osc_tick && deb_cnt_ff == DEB_LAST && !lvl_moved))
        else $error("debounced level moved before the interval");

    AST_DEB_RESTART: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        lvl_moved |=> deb_cnt_ff == DEB_ZERO)
        else $error("debounce count not restarted on change");

    AST_OFF_HOLDS: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !relay_on && !on_rise && !tog_rise |=> !relay_on)
        else $error("relay turned on without a trigger");

endmodule // rtt_relay_timer

/* File: verif/rtt_timebase_model.sv */
// free-running rc timebase stand-in for the timer's oscillator pin
`timescale 1ns/1ps
module rtt_timebase_model
(
    input wire logic sys_clk_i,
    output logic rc_timebase_o = 1'b0
);
    logic [2:0] div_ff = 3'h0;

    // five clocks high, five low: slow enough for the pin synchroniser
    always_ff @(posedge sys_clk_i)
    begin
        div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
        if (div_ff == 3'h4)
        begin
            rc_timebase_o <= ~rc_timebase_o;
        end
    end
endmodule // rtt_timebase_model

/* File: verif/tb.sv */
// self-checking bench for the relay timeout timer
`timescale 1ns/1ps
`define CHK(a, b) \
    begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got %b exp %b", $time, a, b); end end
module tb;
    import rtt_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic osc;
    logic relay;
    logic [2:0] deb;
    rtt_keys_t keys = RTT_KEYS_RST;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    // short counts keep the run brief: 3 and 20 ticks of 10 clocks
    rtt_relay_timer #(.DEBOUNCE_TICKS(3), .DELAY_TICKS(20)) uut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .rc_timebase_input_i(osc), .toggle_i(keys.toggle),
        .sw_on_i(keys.sw_on), .sw_off_i(keys.sw_off),
        .relay_drive_o(relay), .keys_debounced_o(deb));
    rtt_timebase_model tbm (.sys_clk_i(sys_clk_i), .rc_timebase_o(osc));

    // 40 MHz clock
    initial
    begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // cut a hang short
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cw(int k);
        repeat (k) @(posedge sys_clk_i);
    endtask

    // inputs change only by nba at the rising edge
    task automatic drv(logic [2:0] k);
        @(posedge sys_clk_i);
        keys <= k;
    endtask

    // bounded wait, sampled on the falling edge where outputs are settled
    task automatic wrel(logic v, int mx);
        n = 0;
        @(negedge sys_clk_i);
        while (relay !== v && n < mx)
        begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask

    task automatic t_bounce();
        `CHK(relay, 1'b0)
        `CHK(deb, 3'h0)
        drv(3'h4);
        cw(12);
        drv(3'h0);
        cw(60);
        `CHK(relay, 1'b0)
        $display("bounce test done");
    endtask

    task automatic t_toggle();
        drv(3'h4);
        cw(15);
        `CHK(relay, 1'b0)
        wrel(1'b1, 40);
        `CHK({relay, deb}, 4'hC)
        drv(3'h0);
        cw(15);
        `CHK(relay, 1'b1)
        cw(30);
        `CHK(deb, 3'h0)
        drv(3'h4);
        wrel(1'b0, 45);
        `CHK(relay, 1'b0)
        drv(3'h0);
        cw(50);
        $display("toggle test done");
    endtask

    task automatic t_expire();
        drv(3'h4);
        wrel(1'b1, 40);
        drv(3'h0);
        cw(180);
        `CHK(relay, 1'b1)
        wrel(1'b0, 40);
        `CHK(relay, 1'b0)
        // twenty ticks of ten clocks after the accepting edge
        `CHK(n, 20 * 10 - 181)
        $display("expire test done");
    endtask

    // a fresh on press mid-delay must not push the expiry out
    task automatic t_hold_on();
        drv(3'h2);
        wrel(1'b1, 40);
        `CHK(relay, 1'b1)
        cw(40);
        keys <= 3'h0;
        cw(50);
        keys <= 3'h2;
        cw(90);
        `CHK(relay, 1'b1)
        wrel(1'b0, 40);
        `CHK(relay, 1'b0)
        // expiry still on the first activation's schedule
        `CHK(n, 20 * 10 - 180)
        cw(60);
        `CHK(relay, 1'b0)
        drv(3'h0);
        cw(50);
        $display("hold on test done");
    endtask

    task automatic t_off();
        drv(3'h2);
        wrel(1'b1, 40);
        drv(3'h0);
        cw(40);
        drv(3'h1); // off alone here; on and off come together later in this task
        wrel(1'b0, 45);
        `CHK(relay, 1'b0)
        drv(3'h0);
        cw(50);
        drv(3'h3);
        cw(60);
        `CHK({relay, deb}, 4'h3)
        drv(3'h0);
        cw(50);
        $display("off test done");
    endtask

    // power-on reset in mid-run drops an active relay
    task automatic t_reset();
        drv(3'h4);
        wrel(1'b1, 40);
        drv(3'h0);
        cw(40);
        `CHK(relay, 1'b1)
        rst_b_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK({relay, deb}, 4'h0)
        cw(8);
        rst_b_i <= 1'b1;
        cw(60);
        `CHK({relay, deb}, 4'h0)
        $display("reset test done");
    endtask

    // reset held for 8 clocks, then the scenarios
    initial
    begin
        cw(8);
        rst_b_i <= 1'b1;
        cw(2);
        t_bounce();
        t_toggle();
        t_expire();
        t_hold_on();
        t_off();
        t_reset();
        end_sim();
    end
endmodule // tb
